// [rtl/hti_pkg.sv]
// hti_pkg: constants shared by the hardware thread interface files
// assumes one system clock and a host register port with byte offsets
package hti_pkg;

  // ----------------------------------------------------------------
  // host register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_THREAD_IDENTIFIER = 8'h00;
  localparam logic [7:0] REG_COMMAND = 8'h04;
  localparam logic [7:0] REG_THREAD_STATE = 8'h08;
  localparam logic [7:0] REG_START_ARGUMENT = 8'h0c;
  localparam logic [7:0] REG_EXIT_VALUE = 8'h10;
  localparam logic [7:0] REG_RUN_CYCLE_COUNT = 8'h14;

  // ----------------------------------------------------------------
  // field positions and command codes
  // ----------------------------------------------------------------
  localparam int TID_LSB = 24;
  localparam int CMD_LSB = 28;
  localparam logic [3:0] CMD_RUN = 4'h1;
  localparam logic [3:0] CMD_RESET = 4'h2;
  localparam logic [3:0] CMD_COLDBOOT = 4'h4;

  // ----------------------------------------------------------------
  // thread state codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_NOT_USED = 8'h00;
  localparam logic [7:0] ST_USED = 8'h01;
  localparam logic [7:0] ST_RUNNING = 8'h02;
  localparam logic [7:0] ST_LOCK_WAIT = 8'h04;
  localparam logic [7:0] ST_EXITED = 8'h08;
  localparam logic [7:0] ST_EXIT_ERROR = 8'h20;
  localparam logic [7:0] ST_EXIT_OVERFLOW = 8'h40;

  // ----------------------------------------------------------------
  // user opcodes and function codes
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_NOOP = 6'h00;
  localparam logic [5:0] OPC_LOAD = 6'h01;
  localparam logic [5:0] OPC_STORE = 6'h02;
  localparam logic [5:0] OPC_DECLARE = 6'h03;
  localparam logic [5:0] OPC_READ = 6'h04;
  localparam logic [5:0] OPC_WRITE = 6'h05;
  localparam logic [5:0] OPC_LOCAL_POINTER = 6'h06;
  localparam logic [5:0] OPC_PUSH = 6'h07;
  localparam logic [5:0] OPC_POP = 6'h08;
  localparam logic [5:0] OPC_CALL = 6'h09;
  localparam logic [5:0] OPC_RETURN = 6'h0a;

  localparam logic [15:0] FN_RESET = 16'h0000;
  localparam logic [15:0] FN_START = 16'h0002;
  localparam logic [15:0] FN_EXIT = 16'h8000;
  localparam logic [15:0] FN_EXIT_ERROR = 16'h8001;
  localparam logic [15:0] FN_MUTEX_LOCK = 16'h8032;

  // ----------------------------------------------------------------
  // defaults
  // ----------------------------------------------------------------
  localparam int LOCAL_WORDS = 256;
  localparam logic [31:0] LOCAL_BASE_DEFAULT = 32'h0000_0000;

  typedef enum logic [2:0] {OP_IDLE, OP_LM_RD, OP_MEM, OP_DONE, OP_LOCK, OP_HALT} hti_op_t;

endpackage : hti_pkg

// [rtl/hti_local_mem.sv]
// hti_local_mem: local word store for declared variables and pushed values
// assumes single clock, one access per cycle, read data one cycle later
`timescale 1ns/1ps
`default_nettype none
module hti_local_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = hti_pkg::LOCAL_WORDS
) (
  input wire logic mclk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] rdata;
  } hti_lm_state_t;

  logic [WIDTH-1:0] mem [DEPTH];
  hti_lm_state_t s_r;
  hti_lm_state_t s_nxt;

  generate
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
      $error("hti_local_mem: unsupported size");
    end
  endgenerate

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = mem[addr];
  end

  // no reset on the array: contents are undefined until written
  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = s_r.rdata;

endmodule : hti_local_mem
`default_nettype wire

// [rtl/hti_cycle_timer.sv]
// hti_cycle_timer: run cycle counter with clear and enable
// assumes enable and clear come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module hti_cycle_timer #(
  parameter int WIDTH = 32
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clr,
  input wire logic en,
  output logic [WIDTH-1:0] count
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } hti_tm_state_t;

  hti_tm_state_t s_r;
  hti_tm_state_t s_nxt;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("hti_cycle_timer: width must be positive");
    end
  endgenerate

  // wraps silently: at 100 MHz 32 bits last about 42 s
  always_comb begin
    s_nxt = s_r;
    if (clr) begin
      s_nxt.count = '0;
    end else if (en) begin
      s_nxt.count = s_r.count + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count = s_r.count;

endmodule : hti_cycle_timer
`default_nettype wire

// [rtl/hti_thread_interface.sv]
// hti_thread_interface: host registers and user-side go/wait port of a hardware thread
// assumes host port, memory port, lock and user logic all run on mclk
`timescale 1ns/1ps
`default_nettype none
module hti_thread_interface #(
  parameter int DEPTH = hti_pkg::LOCAL_WORDS,
  parameter logic [31:0] LOCAL_BASE = hti_pkg::LOCAL_BASE_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic host_sel,
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  input wire logic [5:0] ul_opcode,
  input wire logic [31:0] ul_addr,
  input wire logic [31:0] ul_value,
  input wire logic [15:0] ul_func,
  output logic [31:0] ti_addr,
  output logic [31:0] ti_value,
  output logic [15:0] ti_func,
  output logic go_wait,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  output logic lock_req,
  output logic [31:0] lock_addr,
  input wire logic lock_grant,
  output logic exit_req
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] thread_state;
    logic [7:0] thread_identifier;
    logic [3:0] last_cmd;
    logic [31:0] start_argument;
    logic [31:0] exit_value;
    hti_pkg::hti_op_t op;
    logic [AW:0] sp;
    logic [31:0] last_push;
    logic [31:0] ti_addr;
    logic [31:0] ti_value;
    logic [15:0] ti_func;
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic lock_req;
    logic [31:0] lock_addr;
    logic exit_req;
    logic [31:0] host_rdata;
  } hti_state_t;

  hti_state_t s_r;
  hti_state_t s_nxt;
  logic lm_we;
  logic [AW-1:0] lm_addr;
  logic [31:0] lm_wdata;
  logic [31:0] lm_rdata;
  logic [31:0] run_count;
  logic running;
  logic req;
  logic host_wr_en;
  logic [3:0] cmd;
  logic cmd_reset;
  logic cmd_run;
  logic timer_en;
  logic [32:0] decl_need;
  logic [31:0] win_off;
  logic in_win;
  logic [AW:0] pop_idx;

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("hti_thread_interface: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  assign running = (s_r.thread_state == hti_pkg::ST_RUNNING);
  assign go_wait = running && (s_r.op == hti_pkg::OP_IDLE);
  assign req = go_wait && (ul_opcode != hti_pkg::OPC_NOOP);
  assign host_wr_en = host_sel && host_wr;
  assign cmd = host_wdata[hti_pkg::CMD_LSB +: 4];
  assign cmd_reset = host_wr_en && (host_addr == hti_pkg::REG_COMMAND) &&
                     (cmd == hti_pkg::CMD_RESET || cmd == hti_pkg::CMD_COLDBOOT);
  assign cmd_run = host_wr_en && (host_addr == hti_pkg::REG_COMMAND) && (cmd == hti_pkg::CMD_RUN);
  assign decl_need = 33'(s_r.sp) + 33'(ul_value);
  assign win_off = ul_addr - LOCAL_BASE;
  assign in_win = win_off < 32'(DEPTH * 4);
  assign pop_idx = s_r.sp - ul_value[AW:0];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    lm_we = 1'b0;
    lm_addr = '0;
    lm_wdata = ul_value;
    s_nxt.lock_req = 1'b0;
    s_nxt.exit_req = 1'b0;

    // host register reads; user-side registers are not in this map
    if (host_sel && !host_wr) begin
      case (host_addr)
        hti_pkg::REG_THREAD_IDENTIFIER: s_nxt.host_rdata = {s_r.thread_identifier, 24'h00_0000};
        hti_pkg::REG_COMMAND: s_nxt.host_rdata = {s_r.last_cmd, 28'h000_0000};
        hti_pkg::REG_THREAD_STATE: s_nxt.host_rdata = {24'h00_0000, s_r.thread_state};
        hti_pkg::REG_START_ARGUMENT: s_nxt.host_rdata = s_r.start_argument;
        hti_pkg::REG_EXIT_VALUE: s_nxt.host_rdata = s_r.exit_value;
        hti_pkg::REG_RUN_CYCLE_COUNT: s_nxt.host_rdata = run_count;
        default: s_nxt.host_rdata = 32'h0000_0000;
      endcase
    end

    // user operations
    case (s_r.op)
      hti_pkg::OP_IDLE: begin
        if (req) begin
          // operands are sampled in the opcode cycle itself
          s_nxt.op = hti_pkg::OP_DONE;
          case (ul_opcode)
            hti_pkg::OPC_LOAD, hti_pkg::OPC_STORE: begin
              if (in_win) begin
                lm_addr = win_off[AW+1:2];
                lm_we = (ul_opcode == hti_pkg::OPC_STORE);
                if (ul_opcode == hti_pkg::OPC_LOAD) begin
                  s_nxt.op = hti_pkg::OP_LM_RD;
                end
              end else begin
                s_nxt.op = hti_pkg::OP_MEM;
                s_nxt.mem_req = 1'b1;
                s_nxt.mem_we = (ul_opcode == hti_pkg::OPC_STORE);
                s_nxt.mem_addr = ul_addr;
                s_nxt.mem_wdata = ul_value;
              end
            end
            hti_pkg::OPC_DECLARE: begin
              if (decl_need > 33'(DEPTH)) begin
                s_nxt.thread_state = hti_pkg::ST_EXIT_OVERFLOW;
                s_nxt.exit_req = 1'b1;
                s_nxt.op = hti_pkg::OP_HALT;
              end else begin
                s_nxt.sp = decl_need[AW:0];
              end
            end
            hti_pkg::OPC_READ: begin
              lm_addr = ul_addr[AW-1:0];
              s_nxt.op = hti_pkg::OP_LM_RD;
            end
            hti_pkg::OPC_WRITE: begin
              lm_addr = ul_addr[AW-1:0];
              lm_we = 1'b1;
            end
            hti_pkg::OPC_LOCAL_POINTER: begin
              s_nxt.ti_addr = LOCAL_BASE + {ul_addr[29:0], 2'b00};
            end
            hti_pkg::OPC_PUSH: begin
              if (s_r.sp == (AW + 1)'(DEPTH)) begin
                s_nxt.thread_state = hti_pkg::ST_EXIT_OVERFLOW;
                s_nxt.exit_req = 1'b1;
                s_nxt.op = hti_pkg::OP_HALT;
              end else begin
                lm_addr = s_r.sp[AW-1:0];
                lm_we = 1'b1;
                s_nxt.sp = s_r.sp + 1'b1;
                s_nxt.last_push = ul_value;
              end
            end
            hti_pkg::OPC_POP: begin
              if (ul_value == 32'h0000_0000) begin
                s_nxt.ti_value = s_r.start_argument;
              end else begin
                lm_addr = pop_idx[AW-1:0];
                s_nxt.op = hti_pkg::OP_LM_RD;
              end
            end
            hti_pkg::OPC_CALL: begin
              case (ul_func)
                hti_pkg::FN_EXIT: begin
                  s_nxt.exit_value = s_r.last_push;
                  s_nxt.thread_state = hti_pkg::ST_EXITED;
                  s_nxt.exit_req = 1'b1;
                  s_nxt.op = hti_pkg::OP_HALT;
                end
                hti_pkg::FN_EXIT_ERROR: begin
                  s_nxt.thread_state = hti_pkg::ST_EXIT_ERROR;
                  s_nxt.exit_req = 1'b1;
                  s_nxt.op = hti_pkg::OP_HALT;
                end
                hti_pkg::FN_MUTEX_LOCK: begin
                  s_nxt.thread_state = hti_pkg::ST_LOCK_WAIT;
                  s_nxt.lock_req = 1'b1;
                  s_nxt.lock_addr = s_r.last_push;
                  s_nxt.op = hti_pkg::OP_LOCK;
                end
                default: begin
                  s_nxt.ti_func = ul_func;
                end
              endcase
            end
            hti_pkg::OPC_RETURN: begin
              // declared words are released here and by a reset command
              s_nxt.sp = '0;
              s_nxt.ti_value = ul_value;
            end
            default: begin
            end
          endcase
        end
      end
      hti_pkg::OP_LM_RD: begin
        s_nxt.ti_value = lm_rdata;
        s_nxt.op = hti_pkg::OP_IDLE;
      end
      hti_pkg::OP_MEM: begin
        if (mem_ack) begin
          s_nxt.mem_req = 1'b0;
          if (!s_r.mem_we) begin
            s_nxt.ti_value = mem_rdata;
          end
          s_nxt.op = hti_pkg::OP_IDLE;
        end
      end
      hti_pkg::OP_DONE: begin
        s_nxt.op = hti_pkg::OP_IDLE;
      end
      hti_pkg::OP_LOCK: begin
        if (lock_grant) begin
          s_nxt.thread_state = hti_pkg::ST_RUNNING;
          s_nxt.op = hti_pkg::OP_DONE;
        end else if (cmd_run) begin
          s_nxt.lock_req = 1'b1;
        end
      end
      hti_pkg::OP_HALT: begin
      end
      default: begin
        s_nxt.op = hti_pkg::OP_IDLE;
      end
    endcase

    // host writes
    if (host_wr_en) begin
      case (host_addr)
        hti_pkg::REG_THREAD_IDENTIFIER: begin
          if (s_r.thread_state == hti_pkg::ST_NOT_USED && host_wdata[hti_pkg::TID_LSB +: 8] != 8'h00) begin
            s_nxt.thread_identifier = host_wdata[hti_pkg::TID_LSB +: 8];
            s_nxt.thread_state = hti_pkg::ST_USED;
          end
        end
        hti_pkg::REG_START_ARGUMENT: begin
          if (s_r.thread_state == hti_pkg::ST_USED) begin
            s_nxt.start_argument = host_wdata;
          end
        end
        hti_pkg::REG_COMMAND: begin
          s_nxt.last_cmd = cmd;
          if (cmd_run && s_r.thread_state == hti_pkg::ST_USED) begin
            s_nxt.thread_state = hti_pkg::ST_RUNNING;
            s_nxt.ti_func = hti_pkg::FN_START;
            s_nxt.op = hti_pkg::OP_IDLE;
          end
        end
        default: begin
        end
      endcase
    end

    // a reset command beats the state, op, stack and request updates of a user event of the same cycle, but not its local memory write
    if (cmd_reset) begin
      s_nxt.thread_state = hti_pkg::ST_NOT_USED;
      s_nxt.thread_identifier = 8'h00;
      s_nxt.op = hti_pkg::OP_IDLE;
      s_nxt.ti_func = hti_pkg::FN_RESET;
      s_nxt.sp = '0;
      s_nxt.mem_req = 1'b0;
      s_nxt.lock_req = 1'b0;
      s_nxt.exit_req = 1'b0;
      if (cmd == hti_pkg::CMD_COLDBOOT) begin
        s_nxt.start_argument = 32'h0000_0000;
        s_nxt.exit_value = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // leaves
  // ----------------------------------------------------------------
  hti_local_mem #(.WIDTH(32), .DEPTH(DEPTH)) u_lmem (
    .mclk(mclk),
    .we(lm_we),
    .addr(lm_addr),
    .wdata(lm_wdata),
    .rdata(lm_rdata)
  );

  // counts while running or waiting on a lock, freezes in any exit state
  assign timer_en = running || (s_r.thread_state == hti_pkg::ST_LOCK_WAIT);

  hti_cycle_timer #(.WIDTH(32)) u_timer (
    .mclk(mclk),
    .rst(rst),
    .clr(cmd_reset),
    .en(timer_en),
    .count(run_count)
  );

  assign host_rdata = s_r.host_rdata;
  assign ti_addr = s_r.ti_addr;
  assign ti_value = s_r.ti_value;
  assign ti_func = s_r.ti_func;
  assign mem_req = s_r.mem_req;
  assign mem_we = s_r.mem_we;
  assign mem_addr = s_r.mem_addr;
  assign mem_wdata = s_r.mem_wdata;
  assign lock_req = s_r.lock_req;
  assign lock_addr = s_r.lock_addr;
  assign exit_req = s_r.exit_req;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_call(logic [15:0] fn);
    req && ul_opcode == hti_pkg::OPC_CALL && ul_func == fn && !cmd_reset;
  endsequence

  property p_tid_used;
    host_wr_en && host_addr == hti_pkg::REG_THREAD_IDENTIFIER && s_r.thread_state == hti_pkg::ST_NOT_USED &&
    host_wdata[31:24] != 8'h00 && !cmd_reset |=> s_r.thread_state == hti_pkg::ST_USED;
  endproperty
  a_tid_used: assert property (p_tid_used) else $error("identifier write did not give used state");

  property p_run;
    cmd_run && s_r.thread_state == hti_pkg::ST_USED |=> running && ti_func == hti_pkg::FN_START && go_wait;
  endproperty
  a_run: assert property (p_run) else $error("run did not start the thread");

  property p_lock;
    s_call(hti_pkg::FN_MUTEX_LOCK) |=> s_r.thread_state == hti_pkg::ST_LOCK_WAIT && lock_req;
  endproperty
  a_lock: assert property (p_lock) else $error("lock call did not block");

  property p_exit;
    s_call(hti_pkg::FN_EXIT) |=> s_r.thread_state == hti_pkg::ST_EXITED && exit_req &&
    s_r.exit_value == $past(s_r.last_push);
  endproperty
  a_exit: assert property (p_exit) else $error("exit call wrong state or value");

  property p_err;
    s_call(hti_pkg::FN_EXIT_ERROR) |=> s_r.thread_state == hti_pkg::ST_EXIT_ERROR && exit_req;
  endproperty
  a_err: assert property (p_err) else $error("error exit not taken");

  property p_ovf;
    req && ul_opcode == hti_pkg::OPC_DECLARE && decl_need > 33'(DEPTH) && !cmd_reset |=>
    s_r.thread_state == hti_pkg::ST_EXIT_OVERFLOW && exit_req ##1 !exit_req && !go_wait;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not handled");

  property p_arg_guard;
    host_wr_en && host_addr == hti_pkg::REG_START_ARGUMENT && s_r.thread_state != hti_pkg::ST_USED && !cmd_reset
    |=> $stable(s_r.start_argument);
  endproperty
  a_arg_guard: assert property (p_arg_guard) else $error("argument written outside used state");

  property p_timer_hold;
    s_r.thread_state == hti_pkg::ST_EXITED && !cmd_reset |=> $stable(run_count);
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("counter moved after exit");

  property p_nodata_done;
    req && (ul_opcode == hti_pkg::OPC_WRITE || ul_opcode == hti_pkg::OPC_LOCAL_POINTER) && !cmd_reset
    |=> !go_wait ##1 go_wait;
  endproperty
  a_nodata_done: assert property (p_nodata_done) else $error("go/wait did not close the request");

  property p_pointer;
    req && ul_opcode == hti_pkg::OPC_LOCAL_POINTER && !cmd_reset |=> ##1
    ti_addr == LOCAL_BASE + {$past(ul_addr[29:0], 2), 2'b00};
  endproperty
  a_pointer: assert property (p_pointer) else $error("wrong local pointer");

  property p_pop0;
    req && ul_opcode == hti_pkg::OPC_POP && ul_value == 32'h0000_0000 && !cmd_reset |=> ##1
    go_wait && ti_value == s_r.start_argument;
  endproperty
  a_pop0: assert property (p_pop0) else $error("pop zero did not return argument");

endmodule : hti_thread_interface
`default_nettype wire

// [verif/hti_mem_model.sv]
// hti_mem_model: far-side memory and lock responder for the thread interface
// assumes requests come from the interface on mclk
`timescale 1ns/1ps
`default_nettype none
module hti_mem_model (
  input wire logic mclk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  input wire logic lock_req,
  output logic lock_grant
);
  // ----------------------------------------------------------------
  // slow answers, so the waits really show at go/wait
  // ----------------------------------------------------------------
  logic [31:0] ram [16];
  int n = 0;
  int k = 0;
  initial begin
    mem_ack = 1'b0;
    lock_grant = 1'b0;
    mem_rdata = 32'h0;
  end
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    lock_grant <= 1'b0;
    mem_rdata <= ~mem_rdata; // outside an ack the data is inverted every cycle
    n <= (mem_req && !mem_ack) ? n + 1 : 0;
    if (n == 3) begin
      mem_ack <= 1'b1;
      if (mem_we) ram[mem_addr[5:2]] <= mem_wdata;
      mem_rdata <= ram[mem_addr[5:2]];
    end
    k <= (lock_req || k != 0) ? k + 1 : 0;
    if (k == 12) begin
      lock_grant <= 1'b1;
      k <= 0;
    end
  end
endmodule : hti_mem_model
`default_nettype wire

// [verif/hti_thread_interface_tb_top.sv]
// hti_thread_interface_tb_top: host register and user port tests
// assumes the memory model answers external loads, stores and lock calls
`timescale 1ns/1ps
`default_nettype none
module hti_thread_interface_tb_top;
  // ----------------------------------------------------------------
  // signals and tasks
  // ----------------------------------------------------------------
  localparam logic [31:0] BASE = 32'h0000_0100;
  localparam logic [31:0] ARG = 32'h1234_5678;
  localparam logic [31:0] EXT = 32'h0000_8010;
  localparam logic [31:0] RES = 32'hcafe_0001;
  localparam logic [7:0] A_ST = hti_pkg::REG_THREAD_STATE;
  localparam logic [7:0] A_AR = hti_pkg::REG_START_ARGUMENT;
  localparam logic [7:0] A_EX = hti_pkg::REG_EXIT_VALUE;
  localparam logic [7:0] A_CT = hti_pkg::REG_RUN_CYCLE_COUNT;
  localparam logic [7:0] A_CM = hti_pkg::REG_COMMAND;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic host_sel = 1'b0;
  logic host_wr = 1'b0;
  logic [7:0] host_addr = 8'h00;
  logic [31:0] host_wdata = 32'h0;
  logic [5:0] ul_opcode = 6'h00;
  logic [31:0] ul_addr = 32'h0;
  logic [31:0] ul_value = 32'h0;
  logic [15:0] ul_func = 16'h0000;
  logic [31:0] host_rdata, ti_addr, ti_value, mem_addr, mem_wdata, mem_rdata, lock_addr, t;
  logic [15:0] ti_func;
  logic go_wait, mem_req, mem_we, mem_ack, lock_req, lock_grant, exit_req;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  hti_thread_interface #(.DEPTH(16), .LOCAL_BASE(BASE)) u_hti_thread_interface (.mclk, .rst, .host_sel,
    .host_wr, .host_addr, .host_wdata, .host_rdata, .ul_opcode, .ul_addr, .ul_value, .ul_func, .ti_addr,
    .ti_value, .ti_func, .go_wait, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .lock_req, .lock_addr, .lock_grant, .exit_req);
  hti_mem_model u_hti_mem_model (.mclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .lock_req, .lock_grant);
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic hw(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    {host_sel, host_wr, host_addr, host_wdata} = {2'b11, a, d};
    @(negedge mclk);
    host_sel = 1'b0;
  endtask : hw
  task automatic hr(input logic [7:0] a, input logic [31:0] e);
    @(negedge mclk);
    {host_sel, host_wr, host_addr} = {2'b10, a};
    @(negedge mclk);
    host_sel = 1'b0;
    chk(host_rdata, e);
  endtask : hr
  task automatic start;
    hw(A_CM, {hti_pkg::CMD_RESET, 28'h0});
    hw(hti_pkg::REG_THREAD_IDENTIFIER, 32'h0900_0000);
    hw(A_CM, {hti_pkg::CMD_RUN, 28'h0});
  endtask : start
  // exit calls never raise go again, so they pass w = 0
  task automatic uop(input logic [5:0] o, input logic [31:0] a, input logic [31:0] v, input logic [15:0] f,
    input bit w);
    int i;
    @(negedge mclk);
    {ul_opcode, ul_addr, ul_value, ul_func} = {o, a, v, f};
    @(negedge mclk);
    ul_opcode = hti_pkg::OPC_NOOP;
    chk({31'h0, go_wait}, 32'h0);
    for (i = 0; w && i < 50 && go_wait !== 1'b1; i++) @(negedge mclk);
    if (w) chk({31'h0, go_wait}, 32'h1);
  endtask : uop
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      wrap_up;
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    hr(A_ST, 32'h0);
    hw(A_AR, 32'h1111_2222);
    hr(A_AR, 32'h0);
    hw(A_CM, {hti_pkg::CMD_RESET, 28'h0});
    hr(A_CT, 32'h0);
    hw(hti_pkg::REG_THREAD_IDENTIFIER, 32'h0500_0000);
    hr(A_ST, {24'h0, hti_pkg::ST_USED});
    hw(A_AR, ARG);
    hr(A_AR, ARG);
    hw(A_CM, {hti_pkg::CMD_RUN, 28'h0});
    t = 32'(cyc);
    hr(A_ST, {24'h0, hti_pkg::ST_RUNNING});
    hw(A_AR, 32'h0);
    hr(A_AR, ARG);
    hr(8'h20, 32'h0);
    chk({16'h0, ti_func}, {16'h0, hti_pkg::FN_START});
    $display("test host registers finished");
    uop(hti_pkg::OPC_POP, 32'h0, 32'h0, 16'h0, 1'b1);
    chk(ti_value, ARG);
    uop(hti_pkg::OPC_DECLARE, 32'h0, 32'h4, 16'h0, 1'b1);
    uop(hti_pkg::OPC_WRITE, 32'h2, 32'h0000_00aa, 16'h0, 1'b1);
    uop(hti_pkg::OPC_READ, 32'h2, 32'h0, 16'h0, 1'b1);
    chk(ti_value, 32'h0000_00aa);
    uop(hti_pkg::OPC_LOCAL_POINTER, 32'h2, 32'h0, 16'h0, 1'b1);
    chk(ti_addr, BASE + 32'h8);
    uop(hti_pkg::OPC_LOAD, BASE + 32'h8, 32'h0, 16'h0, 1'b1);
    chk(ti_value, 32'h0000_00aa);
    uop(hti_pkg::OPC_STORE, BASE + 32'hc, 32'h0000_0077, 16'h0, 1'b1);
    uop(hti_pkg::OPC_READ, 32'h3, 32'h0, 16'h0, 1'b1);
    chk(ti_value, 32'h0000_0077);
    uop(hti_pkg::OPC_STORE, EXT, 32'h5a5a_0033, 16'h0, 1'b1);
    uop(hti_pkg::OPC_LOAD, EXT, 32'h0, 16'h0, 1'b1);
    chk(ti_value, 32'h5a5a_0033);
    chk(mem_addr, EXT);
    $display("test user memory finished");
    uop(hti_pkg::OPC_PUSH, 32'h0, 32'h0023_8f20, 16'h0, 1'b1);
    fork
      uop(hti_pkg::OPC_CALL, 32'h0, 32'h0, hti_pkg::FN_MUTEX_LOCK, 1'b1);
      begin
        repeat (4) @(negedge mclk);
        hr(A_ST, {24'h0, hti_pkg::ST_LOCK_WAIT});
      end
    join
    chk(lock_addr, 32'h0023_8f20);
    hr(A_ST, {24'h0, hti_pkg::ST_RUNNING});
    uop(hti_pkg::OPC_PUSH, 32'h0, RES, 16'h0, 1'b1);
    uop(hti_pkg::OPC_CALL, 32'h0, 32'h0, hti_pkg::FN_EXIT, 1'b0);
    t = 32'(cyc) - t;
    chk({31'h0, exit_req}, 32'h1);
    hr(A_ST, {24'h0, hti_pkg::ST_EXITED});
    hw(A_EX, 32'h0);
    hr(A_EX, RES);
    hr(A_CT, t);
    hr(A_CT, t);
    $display("test lock and exit finished");
    start();
    uop(hti_pkg::OPC_CALL, 32'h0, 32'h0, hti_pkg::FN_EXIT_ERROR, 1'b0);
    chk({31'h0, exit_req}, 32'h1);
    hr(A_ST, {24'h0, hti_pkg::ST_EXIT_ERROR});
    start();
    uop(hti_pkg::OPC_DECLARE, 32'h0, 32'd17, 16'h0, 1'b0);
    chk({31'h0, exit_req}, 32'h1);
    hr(A_ST, {24'h0, hti_pkg::ST_EXIT_OVERFLOW});
    hw(A_CM, {hti_pkg::CMD_COLDBOOT, 28'h0});
    hr(A_ST, 32'h0);
    hr(A_CT, 32'h0);
    $display("test error exits finished");
    wrap_up;
  end
endmodule : hti_thread_interface_tb_top
`default_nettype wire
